// ==== hdl/rsic_defs.vh ====
// constants for the reset initial state controller
`ifndef RSIC_DEFS_VH
`define RSIC_DEFS_VH

// ****************************************
// bus register byte offsets
// ****************************************
`define RSIC_OFS_FLAGS      8'h00
`define RSIC_OFS_RSTFLAG    8'h04
`define RSIC_OFS_IRQ_STS    8'h08
`define RSIC_OFS_IRQ_CLR    8'h0C
`define RSIC_OFS_IRQ_EN     8'h10
`define RSIC_OFS_LAST       8'h14
`define RSIC_OFS_VIEW       8'h40

// ****************************************
// field positions
// ****************************************
`define RSIC_BIT_TIMEOUT    0
`define RSIC_BIT_POWERDOWN  1
`define RSIC_BIT_LVR        2

// ****************************************
// reset sources and power modes
// ****************************************
`define RSIC_SRC_POR        2'h0
`define RSIC_SRC_LVR        2'h1
`define RSIC_SRC_WDT        2'h2
`define RSIC_MODE_FAST      2'h0
`define RSIC_MODE_SLOW      2'h1
`define RSIC_MODE_IDLE      2'h2
`define RSIC_MODE_SLEEP     2'h3

// ****************************************
// held register indices
// ****************************************
`define RSIC_NREG           15
`define RSIC_IX_PCL         4'h0
`define RSIC_IX_SP          4'h1
`define RSIC_IX_ACC         4'h2
`define RSIC_IX_TABLE_POINTER_LOW        4'h3
`define RSIC_IX_TABLE_READ_HIGH        4'h4
`define RSIC_IX_INTEN       4'h5
`define RSIC_IX_TMRC        4'h6
`define RSIC_IX_WATCHDOG_CONTROL_REG        4'h7
`define RSIC_IX_PAD         4'h8
`define RSIC_IX_PADIR       4'h9
`define RSIC_IX_PORT_A_PULLUP        4'hA
`define RSIC_IX_PORT_A_WAKEUP        4'hB
`define RSIC_IX_PBD         4'hC
`define RSIC_IX_PBDIR       4'hD
`define RSIC_IX_PORT_B_PULLUP        4'hE

// entries kept over a run-mode watchdog or low-voltage reset
`define RSIC_KEEP_MASK      15'h001C
// entries cleared by a watchdog reset in idle or sleep
`define RSIC_SLEEP_MASK     15'h0003

// ****************************************
// default values
// ****************************************
`define RSIC_DEF_ZERO       8'h00
`define RSIC_DEF_WATCHDOG_CONTROL_REG       8'h53
`define RSIC_DEF_PORT       8'hFF
`define RSIC_DEF_SP         8'h00

`endif

// ==== hdl/rsic_reset_init.v ====
// reset source recording and register default loading with a bus slave
// Notes on behaviour
// RULE_01: power-on reset clears the time-out and power-down flags.
// RULE_02: low-voltage reset in fast or slow mode keeps both flags.
// RULE_03: run-mode watchdog reset sets time-out, keeps power-down.
// RULE_04: idle or sleep watchdog reset sets both flags.
// RULE_05: power-on reset zeroes the program counter.
// RULE_06: power-on reset clears every interrupt enable.
// RULE_07: reset clears watchdog and time bases; watchdog control loads 0x53. The code keeps watchdog control on an idle or sleep watchdog reset.
// RULE_08: power-on reset turns timer controls off.
// RULE_09: ports load data and direction 0xFF, pull-up and wake-up 0x00.
// RULE_10: reset points the stack pointer at the stack top.
// RULE_11: run-mode watchdog reset loads defaults but keeps accumulator and table regs.
// RULE_12: sleep watchdog reset keeps registers, clears program counter low byte.
// RULE_13: sleep watchdog reset touches only program counter and stack pointer.
// RULE_14: low-voltage event sets its flag; only software clears it. The code sets it only in fast or slow mode and also clears it at power-on.
// RULE_15: reset source and power mode are latched to pick the defaults.
`timescale 1ns/1ns
`include "rsic_defs.vh"

module rsic_reset_init (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [1:0]  pwr_mode,
    input  wire        lvr_req,
    input  wire        wdt_req,
    input  wire        core_halt,
    input  wire        core_we,
    input  wire [3:0]  core_sel,
    input  wire [7:0]  core_wdata,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         irq,
    output reg         core_reset,
    output reg         wdt_clear,
    output reg         tb_clear,
    output reg         timeout_flag,
    output reg         powerdown_flag,
    output reg         low_voltage_reset_flag,
    output wire [7:0]  program_counter_low,
    output wire [7:0]  stack_pointer,
    output wire [7:0]  accumulator_reg,
    output wire [7:0]  table_pointer_low,
    output wire [7:0]  table_read_high,
    output wire [7:0]  int_enable,
    output wire [7:0]  timer_control,
    output wire [7:0]  watchdog_control_reg,
    output wire [7:0]  port_a_data,
    output wire [7:0]  port_a_direction,
    output wire [7:0]  port_a_pullup,
    output wire [7:0]  port_a_wakeup,
    output wire [7:0]  port_b_data,
    output wire [7:0]  port_b_direction,
    output wire [7:0]  port_b_pullup
);

    // ****************************************
    // sequencer states
    // ****************************************
    localparam ST_IDLE  = 1'b0;
    localparam ST_APPLY = 1'b1;

    reg        state;
    reg        next_state;
    reg  [1:0] src;
    reg  [1:0] mode;
    reg  [7:0] hreg [0:`RSIC_NREG-1];
    reg  [3:0] irq_sts;
    reg  [3:0] irq_en;
    reg  [31:0] next_rdata;

    // per-entry masks as ranged constants so each entry picks its own bit
    localparam [14:0] SLEEP_M = `RSIC_SLEEP_MASK;
    localparam [14:0] KEEP_M  = `RSIC_KEEP_MASK;

    wire       low_power   = mode[1];
    wire       lvr_ok      = lvr_req & ~pwr_mode[1];
    wire       take_req    = (state == ST_IDLE) & (lvr_ok | wdt_req);
    wire       apply       = (state == ST_APPLY);
    wire       src_por     = (src == `RSIC_SRC_POR);
    wire       src_lvr     = (src == `RSIC_SRC_LVR);
    wire       src_wdt     = (src == `RSIC_SRC_WDT);
    wire       wdt_sleep   = src_wdt & low_power;
    wire       bus_req     = avs_read | avs_write;
    wire       bus_do      = bus_req & ~avs_waitrequest;
    wire       bus_wr      = avs_write & ~avs_waitrequest;
    wire [3:0] view_ix     = avs_address[5:2];
    wire [3:0] irq_events;
    wire [7:0] flags_byte;

    // events: power-on done, low-voltage, run watchdog, sleep watchdog
    assign irq_events = {4{apply}} & {wdt_sleep, src_wdt & ~low_power, src_lvr, src_por};
    assign flags_byte = {5'h00, low_voltage_reset_flag, powerdown_flag, timeout_flag};

    // ****************************************
    // default value per held entry
    // ****************************************
    function [7:0] def_val;
        input integer ix;
        begin
            case (ix)
                `RSIC_IX_WATCHDOG_CONTROL_REG:  def_val = `RSIC_DEF_WATCHDOG_CONTROL_REG;  // [RULE_07]
                `RSIC_IX_PAD,
                `RSIC_IX_PADIR,
                `RSIC_IX_PBD,
                `RSIC_IX_PBDIR: def_val = `RSIC_DEF_PORT;  // [RULE_09]
                `RSIC_IX_SP:    def_val = `RSIC_DEF_SP;    // [RULE_10]
                default:        def_val = `RSIC_DEF_ZERO;  // [RULE_05] [RULE_06] [RULE_08]
            endcase
        end
    endfunction

    // ****************************************
    // source latch and sequencer
    // ****************************************

    // next state: one apply cycle per accepted request
    always @* begin
        case (state)
            ST_IDLE:  next_state = take_req ? ST_APPLY : ST_IDLE;
            ST_APPLY: next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    // latch source and mode; power-on starts in apply
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state      <= ST_APPLY;
            src        <= `RSIC_SRC_POR;
            mode       <= `RSIC_MODE_FAST;
            core_reset <= 1'b1;
            wdt_clear  <= 1'b1;
            tb_clear   <= 1'b1;
        end else begin
            state      <= next_state;
            core_reset <= (next_state == ST_APPLY);
            wdt_clear  <= (next_state == ST_APPLY);  // [RULE_07]
            tb_clear   <= (next_state == ST_APPLY);  // [RULE_07]
            if (take_req) begin
                src  <= lvr_ok ? `RSIC_SRC_LVR : `RSIC_SRC_WDT;  // [RULE_15]
                mode <= pwr_mode;                                 // [RULE_15]
            end
        end
    end

    // ****************************************
    // status flags
    // ****************************************

    // time-out and power-down follow the latched source
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timeout_flag   <= 1'b0;  // [RULE_01]
            powerdown_flag <= 1'b0;  // [RULE_01]
        end else if (apply) begin
            if (src_por) begin
                timeout_flag   <= 1'b0;  // [RULE_01]
                powerdown_flag <= 1'b0;
            end else if (src_wdt) begin
                timeout_flag   <= 1'b1;  // [RULE_03] [RULE_04]
                if (low_power) begin
                    powerdown_flag <= 1'b1;  // [RULE_04]
                end
            end
            // low-voltage source keeps both flags [RULE_02]
        end else if (core_halt) begin
            powerdown_flag <= 1'b1;
        end
    end

    // low-voltage flag: set wins over a software clear
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_voltage_reset_flag <= 1'b0;
        end else if (take_req && lvr_ok) begin
            low_voltage_reset_flag <= 1'b1;  // [RULE_14]
        end else if (bus_wr && avs_address == `RSIC_OFS_RSTFLAG &&
                     !avs_writedata[`RSIC_BIT_LVR]) begin
            low_voltage_reset_flag <= 1'b0;  // [RULE_14]
        end
    end

    // ****************************************
    // held core registers
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < `RSIC_NREG; gi = gi + 1) begin : g_hold
            // defaults chosen by latched source and mode
            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    hreg[gi] <= def_val(gi);  // [RULE_05] [RULE_10]
                end else if (apply) begin
                    if (src_por) begin
                        hreg[gi] <= def_val(gi);  // [RULE_06] [RULE_08] [RULE_09]
                    end else if (wdt_sleep) begin
                        if (SLEEP_M[gi]) begin
                            hreg[gi] <= def_val(gi);  // [RULE_12] [RULE_13]
                        end
                    end else if (!KEEP_M[gi]) begin
                        hreg[gi] <= def_val(gi);  // [RULE_07] [RULE_11]
                    end
                end else if (core_we && core_sel == gi) begin
                    hreg[gi] <= core_wdata;
                end
            end
        end
    endgenerate

    assign program_counter_low  = hreg[`RSIC_IX_PCL];
    assign stack_pointer        = hreg[`RSIC_IX_SP];
    assign accumulator_reg      = hreg[`RSIC_IX_ACC];
    assign table_pointer_low    = hreg[`RSIC_IX_TABLE_POINTER_LOW];
    assign table_read_high      = hreg[`RSIC_IX_TABLE_READ_HIGH];
    assign int_enable           = hreg[`RSIC_IX_INTEN];
    assign timer_control        = hreg[`RSIC_IX_TMRC];
    assign watchdog_control_reg = hreg[`RSIC_IX_WATCHDOG_CONTROL_REG];
    assign port_a_data          = hreg[`RSIC_IX_PAD];
    assign port_a_direction     = hreg[`RSIC_IX_PADIR];
    assign port_a_pullup        = hreg[`RSIC_IX_PORT_A_PULLUP];
    assign port_a_wakeup        = hreg[`RSIC_IX_PORT_A_WAKEUP];
    assign port_b_data          = hreg[`RSIC_IX_PBD];
    assign port_b_direction     = hreg[`RSIC_IX_PBDIR];
    assign port_b_pullup        = hreg[`RSIC_IX_PORT_B_PULLUP];

    // ****************************************
    // interrupt status, enable and clear
    // ****************************************

    // sticky events, set wins over write-one clear
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_sts <= 4'h0;
            irq_en  <= 4'h0;
            irq     <= 1'b0;
        end else begin
            if (bus_wr && avs_address == `RSIC_OFS_IRQ_CLR) begin
                irq_sts <= (irq_sts & ~avs_writedata[3:0]) | irq_events;
            end else begin
                irq_sts <= irq_sts | irq_events;
            end
            if (bus_wr && avs_address == `RSIC_OFS_IRQ_EN) begin
                irq_en <= avs_writedata[3:0];
            end
            irq <= |(irq_sts & irq_en);
        end
    end

    // ****************************************
    // avalon slave
    // ****************************************

    // read mux, unmapped addresses read zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (avs_address)
            `RSIC_OFS_FLAGS:   next_rdata = {24'h00_0000, flags_byte};
            `RSIC_OFS_RSTFLAG: next_rdata = {29'h0000_0000, low_voltage_reset_flag, 2'h0};
            `RSIC_OFS_IRQ_STS: next_rdata = {28'h000_0000, irq_sts};
            `RSIC_OFS_IRQ_EN:  next_rdata = {28'h000_0000, irq_en};
            `RSIC_OFS_LAST:    next_rdata = {27'h000_0000, state, mode, src};
            default: begin
                if (avs_address[7:6] == 2'h1 && avs_address[1:0] == 2'h0 &&
                    view_ix < `RSIC_NREG) begin
                    next_rdata = {24'h00_0000, hreg[view_ix]};
                end
            end
        endcase
    end

    // one wait cycle per request, data stands at the release edge
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= next_rdata;
            end
        end
    end

endmodule

// ==== testbench/rsic_reset_init_asserts.sv ====
// port-level checks on the reset initial state controller
`timescale 1ns/1ns
module rsic_reset_init_asserts (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic [1:0] pwr_mode,
    input wire logic       lvr_req,
    input wire logic       wdt_req,
    input wire logic       core_reset,
    input wire logic       wdt_clear,
    input wire logic       tb_clear,
    input wire logic       timeout_flag,
    input wire logic       powerdown_flag,
    input wire logic       low_voltage_reset_flag,
    input wire logic [7:0] program_counter_low,
    input wire logic [7:0] stack_pointer,
    input wire logic [7:0] accumulator_reg,
    input wire logic [7:0] int_enable,
    input wire logic [7:0] timer_control,
    input wire logic [7:0] watchdog_control_reg,
    input wire logic [7:0] port_a_data,
    input wire logic [7:0] port_a_pullup
);
    // ****************************************
    // request decode and properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // requests the block takes, low voltage first
    wire lvr_go = lvr_req && !pwr_mode[1] && !core_reset;
    wire wdt_go = wdt_req && !lvr_go && !core_reset;

    a_por_flags: assert property ($rose(nrst) |-> !timeout_flag && !powerdown_flag)
        else $error("flags not clear after power-on");
    a_por_core_defaults: assert property ($rose(nrst) |->
        program_counter_low == 8'h00 && int_enable == 8'h00 &&
        timer_control == 8'h00 && stack_pointer == 8'h00)
        else $error("core defaults wrong after power-on");
    a_por_io_defaults: assert property ($rose(nrst) |->
        watchdog_control_reg == 8'h53 && port_a_data == 8'hFF && port_a_pullup == 8'h00)
        else $error("io defaults wrong after power-on");
    a_reset_one_cycle: assert property ($rose(core_reset) |=> !core_reset)
        else $error("core reset longer than one cycle");
    a_clears_follow: assert property (wdt_clear == core_reset && tb_clear == core_reset)
        else $error("counter clears out of step");
    a_run_wdt_load: assert property (wdt_go && !pwr_mode[1] |->
        ##1 core_reset ##1 timeout_flag && $stable(accumulator_reg) &&
        port_a_data == 8'hFF && watchdog_control_reg == 8'h53 && int_enable == 8'h00)
        else $error("run watchdog reset wrong");
    a_sleep_wdt_load: assert property (wdt_go && pwr_mode[1] |->
        ##2 timeout_flag && powerdown_flag && program_counter_low == 8'h00 &&
        stack_pointer == 8'h00 && $stable(port_a_data) && $stable(watchdog_control_reg))
        else $error("sleep watchdog reset wrong");
    a_lvr_keeps_flags: assert property (lvr_go |=> core_reset ##1
        $stable(timeout_flag) && $stable(accumulator_reg))
        else $error("low voltage reset changed kept state");
    a_lvr_sets_flag: assert property (lvr_go |=> low_voltage_reset_flag)
        else $error("low voltage flag not set");

    c_run_wdt: cover property (wdt_go && !pwr_mode[1]);
    c_sleep_wdt: cover property (wdt_go && pwr_mode[1]);
    c_lvr: cover property (lvr_go);
endmodule

// ==== testbench/rsic_core_model.sv ====
// behavioural core: power mode, reset requests, halt and entry writes
`timescale 1ns/1ns
module rsic_core_model (
    input  wire logic  clk_sys,
    output logic [1:0] pwr_mode,
    output logic       lvr_req,
    output logic       wdt_req,
    output logic       core_halt,
    output logic       core_we,
    output logic [3:0] core_sel,
    output logic [7:0] core_wdata
);
    // ****************************************
    // stimulus tasks
    // ****************************************
    initial begin
        pwr_mode = 2'h0;
        lvr_req = 1'b0;
        wdt_req = 1'b0;
        core_halt = 1'b0;
        core_we = 1'b0;
        core_sel = 4'h0;
        core_wdata = 8'h00;
    end
    // one-cycle request, then wait out the apply cycle
    task req(input logic [1:0] m, input logic low_voltage_reset);
        @(posedge clk_sys);
        pwr_mode <= m;
        lvr_req <= low_voltage_reset;
        wdt_req <= !low_voltage_reset;
        @(posedge clk_sys);
        lvr_req <= 1'b0;
        wdt_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // one-cycle write of a held entry
    task wr(input logic [3:0] ix, input logic [7:0] v);
        @(posedge clk_sys);
        core_we <= 1'b1;
        core_sel <= ix;
        core_wdata <= v;
        @(posedge clk_sys);
        core_we <= 1'b0;
    endtask
    task halt;
        @(posedge clk_sys);
        core_halt <= 1'b1;
        @(posedge clk_sys);
        core_halt <= 1'b0;
    endtask
endmodule

// ==== testbench/rsic_reset_init_test.sv ====
// self-checking bench for the reset initial state controller
`timescale 1ns/1ns
`include "rsic_defs.vh"
module rsic_reset_init_test;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rdat;
    logic        avs_waitrequest, irq, core_reset, wdt_clear, tb_clear, core_halt, core_we;
    logic        timeout_flag, powerdown_flag, low_voltage_reset_flag, lvr_req, wdt_req;
    logic [1:0]  pwr_mode;
    logic [3:0]  core_sel;
    logic [7:0]  core_wdata, program_counter_low, stack_pointer, accumulator_reg;
    logic [7:0]  table_pointer_low, table_read_high, int_enable, timer_control;
    logic [7:0]  watchdog_control_reg, port_a_data, port_a_direction, port_a_pullup;
    logic [7:0]  port_a_wakeup, port_b_data, port_b_direction, port_b_pullup;
    int          bad_count = 0;
    int          n_checks = 0;

    rsic_reset_init DUT (
        .clk_sys(clk_sys), .nrst(nrst), .pwr_mode(pwr_mode), .lvr_req(lvr_req),
        .wdt_req(wdt_req), .core_halt(core_halt), .core_we(core_we), .core_sel(core_sel),
        .core_wdata(core_wdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .core_reset(core_reset),
        .wdt_clear(wdt_clear), .tb_clear(tb_clear), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag), .low_voltage_reset_flag(low_voltage_reset_flag),
        .program_counter_low(program_counter_low), .stack_pointer(stack_pointer),
        .accumulator_reg(accumulator_reg), .table_pointer_low(table_pointer_low),
        .table_read_high(table_read_high), .int_enable(int_enable),
        .timer_control(timer_control), .watchdog_control_reg(watchdog_control_reg),
        .port_a_data(port_a_data), .port_a_direction(port_a_direction),
        .port_a_pullup(port_a_pullup), .port_a_wakeup(port_a_wakeup),
        .port_b_data(port_b_data), .port_b_direction(port_b_direction),
        .port_b_pullup(port_b_pullup)
    );
    rsic_core_model u_core (
        .clk_sys(clk_sys), .pwr_mode(pwr_mode), .lvr_req(lvr_req), .wdt_req(wdt_req),
        .core_halt(core_halt), .core_we(core_we), .core_sel(core_sel),
        .core_wdata(core_wdata)
    );

    // ****************************************
    // clock, shared tasks and scenarios
    // ****************************************
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // one bus access, held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rdat);
    endtask
    task t_por;
        repeat (3) @(posedge clk_sys);
        chk("flags", 3'h0, {low_voltage_reset_flag, powerdown_flag, timeout_flag});
        chk("pcl", 8'h00, program_counter_low);
        chk("int_en", 8'h00, int_enable);
        chk("timer", 8'h00, timer_control);
        chk("watchdog_control_reg", 8'h53, watchdog_control_reg);
        chk("ports", 32'hFFFFFFFF, {port_a_data, port_a_direction, port_b_data,
            port_b_direction});
        chk("pulls", 24'h0, {port_a_pullup, port_a_wakeup, port_b_pullup});
        chk("sp", 8'h00, stack_pointer);
        rchk("flag_reg", `RSIC_OFS_FLAGS, 32'h0);
        rchk("unmapped", 8'h30, 32'h0);
        $display("test power-on done");
    endtask
    task t_run_wdt;
        u_core.wr(`RSIC_IX_ACC, 8'h5A);
        u_core.wr(`RSIC_IX_PAD, 8'h12);
        u_core.wr(`RSIC_IX_WATCHDOG_CONTROL_REG, 8'h11);
        u_core.wr(`RSIC_IX_INTEN, 8'h0F);
        u_core.wr(`RSIC_IX_TABLE_POINTER_LOW, 8'hA5);
        u_core.wr(`RSIC_IX_TABLE_READ_HIGH, 8'h3C);
        u_core.req(`RSIC_MODE_FAST, 1'b0);
        chk("tbl", 16'hA53C, {table_pointer_low, table_read_high});
        chk("to_pd", 2'b01, {powerdown_flag, timeout_flag});
        chk("acc", 8'h5A, accumulator_reg);
        chk("pa", 8'hFF, port_a_data);
        chk("watchdog_control_reg", 8'h53, watchdog_control_reg);
        chk("int_en", 8'h00, int_enable);
        $display("test run watchdog done");
    endtask
    task t_sleep_wdt;
        u_core.wr(`RSIC_IX_PAD, 8'h34);
        u_core.wr(`RSIC_IX_PCL, 8'h77);
        u_core.wr(`RSIC_IX_SP, 8'h09);
        u_core.req(`RSIC_MODE_IDLE, 1'b0);
        chk("to_pd", 2'b11, {powerdown_flag, timeout_flag});
        chk("pcl_sp", 16'h0, {program_counter_low, stack_pointer});
        chk("pa", 8'h34, port_a_data);
        chk("acc", 8'h5A, accumulator_reg);
        $display("test sleep watchdog done");
    endtask
    task t_lvr;
        u_core.req(`RSIC_MODE_SLEEP, 1'b1);
        chk("lvr_sleep", 1'b0, low_voltage_reset_flag);
        u_core.req(`RSIC_MODE_SLOW, 1'b1);
        chk("lvr_flag", 1'b1, low_voltage_reset_flag);
        chk("to_pd", 2'b11, {powerdown_flag, timeout_flag});
        bus(1'b1, `RSIC_OFS_RSTFLAG, 32'h0);
        rchk("flag_reg", `RSIC_OFS_FLAGS, 32'h3);
        $display("test low voltage done");
    endtask
    task t_irq;
        rchk("irq_sts", `RSIC_OFS_IRQ_STS, 32'hF);
        chk("irq_idle", 1'b0, irq);
        bus(1'b1, `RSIC_OFS_IRQ_EN, 32'h4);
        repeat (2) @(posedge clk_sys);
        chk("irq_on", 1'b1, irq);
        rchk("irq_en", `RSIC_OFS_IRQ_EN, 32'h4);
        rchk("last", `RSIC_OFS_LAST, 32'h5);
        rchk("view_acc", `RSIC_OFS_VIEW + 8'h08, 32'h5A);
        bus(1'b1, `RSIC_OFS_IRQ_CLR, 32'h4);
        repeat (2) @(posedge clk_sys);
        chk("irq_masked", 1'b0, irq);
        rchk("irq_left", `RSIC_OFS_IRQ_STS, 32'hB);
        $display("test interrupt done");
    endtask
    // mid-run power-on reset, then a halt sets only the power-down flag
    task t_rst2;
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("flags2", 3'h0, {low_voltage_reset_flag, powerdown_flag, timeout_flag});
        chk("acc2", 8'h00, accumulator_reg);
        chk("wdtc2", 8'h53, watchdog_control_reg);
        chk("core_reset", 1'b0, core_reset);
        rchk("irq_sts2", `RSIC_OFS_IRQ_STS, 32'h1);
        u_core.halt;
        @(posedge clk_sys);
        chk("halt_pd", 2'b10, {powerdown_flag, timeout_flag});
        $display("test second reset done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        t_por;
        t_run_wdt;
        t_sleep_wdt;
        t_lvr;
        t_irq;
        t_rst2;
        test_done;
    end
    // hang guard
    initial begin
        #200000;
        bad_count++;
        test_done;
    end
endmodule

bind rsic_reset_init rsic_reset_init_asserts u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .pwr_mode(pwr_mode), .lvr_req(lvr_req),
    .wdt_req(wdt_req), .core_reset(core_reset), .wdt_clear(wdt_clear),
    .tb_clear(tb_clear), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .low_voltage_reset_flag(low_voltage_reset_flag),
    .program_counter_low(program_counter_low), .stack_pointer(stack_pointer),
    .accumulator_reg(accumulator_reg), .int_enable(int_enable),
    .timer_control(timer_control), .watchdog_control_reg(watchdog_control_reg),
    .port_a_data(port_a_data), .port_a_pullup(port_a_pullup)
);
